// >>> rtl/ict_core.sv
`timescale 1ns/100ps
// Summary of operation
// RULE1 - an instruction cycle is exactly four system clocks.
// RULE2 - plain instructions take one cycle; jump, call, returns, table read take two.
// RULE3 - writing the program counter low byte jumps there and costs one more cycle.
// RULE4 - a conditional skip takes one cycle, two when the skip is taken.
// RULE5 - conditional tests of a byte or bit continue or skip the next instruction.
// RULE6 - call saves the address after it for return; jump saves nothing.
// RULE7 - add carries past 255; subtract flags a borrow below zero.
// RULE8 - increment and decrement change by one, to memory or accumulator.
// RULE9 - and, or, xor, complement go via accumulator and set zero flag.
// RULE10 - rotates move one bit; through-carry forms shift the lost bit into carry.
// RULE11 - bit set and clear read-modify-write, keeping the other seven bits.
// RULE12 - table read fetches program memory data into the datapath in two cycles.
// RULE13 - data memory instructions reach sector 0 directly, no other sector.
// RULE14 - interrupt return sets global interrupt enable; plain return leaves it.
// RULE15 - on jump, taken skip or counter write the prefetched slot is discarded.
module ict_core (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic [ict_pkg::INSTR_W-1:0]   pmem_data_i,
	input  wire logic [ict_pkg::DATA_W-1:0]    dmem_rdata_i,
	output logic      [ict_pkg::PC_W-1:0]      pmem_addr_o,
	output logic      [ict_pkg::DATA_W-1:0]    dmem_addr_o,
	output logic      [ict_pkg::DATA_W-1:0]    dmem_wdata_o,
	output logic                               dmem_we_o,
	output logic      [ict_pkg::DATA_W-1:0]    acc_o,
	output logic                               carry_o,
	output logic                               zero_o,
	output logic                               global_interrupt_enable_o,
	output logic                               instr_cycle_o
);
	import ict_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		ict_seq_t                          seq;
		logic [PC_W-1:0]                   pc;
		logic [PC_W-1:0]                   pmem_addr;
		logic [INSTR_W-1:0]                ir;
		logic [PC_W-1:0]                   tblp;
		logic [DATA_W-1:0]                 acc;
		logic                              carry;
		logic                              zero;
		logic                              gie;
		logic [STACK_DEPTH-1:0][PC_W-1:0]  stack;
		logic [SP_W-1:0]                   sp;
		logic [DATA_W-1:0]                 dmem_addr;
		logic [DATA_W-1:0]                 wdata;
		logic                              we;
		logic                              cyc;
	} ict_core_state_t;

	ict_core_state_t s_reg;
	ict_core_state_t s_next;

	logic            exec_en;
	logic            fetch_en;
	logic [4:0]      opc;
	logic            to_mem;
	logic [2:0]      bsel;
	logic [7:0]      opnd;
	logic [SP_W-1:0] sp_dec;

	ict_alu_if alu_bus ();

	ict_phase u_phase (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.exec_o  (exec_en),
		.fetch_o (fetch_en)
	);

	ict_alu u_alu (
		.port_a (alu_bus)
	);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	function automatic logic has_dest_bit(input logic [4:0] op);
		return (op >= OP_ADD) && (op <= OP_RLC);
	endfunction

	function automatic ict_alu_op_t alu_sel(input logic [4:0] op);
		case (op)
			OP_ADD, OP_ADDX: return ALU_ADD;
			OP_SUB, OP_SUBX: return ALU_SUB;
			OP_AND, OP_ANDX: return ALU_AND;
			OP_OR,  OP_ORX:  return ALU_OR;
			OP_XOR, OP_XORX: return ALU_XOR;
			OP_CPL:          return ALU_CPL;
			OP_INC:          return ALU_INC;
			OP_DEC:          return ALU_DEC;
			OP_RR:           return ALU_RR;
			OP_RL:           return ALU_RL;
			OP_RRC:          return ALU_RRC;
			OP_RLC:          return ALU_RLC;
			OP_SETB:         return ALU_SETB;
			OP_CLRB:         return ALU_CLRB;
			default:         return ALU_PASS;
		endcase
	endfunction

	assign opc    = s_reg.ir[OPC_MSB:OPC_LSB];
	assign bsel   = s_reg.ir[DEST_BIT:DEST_BIT-2];
	assign to_mem = (has_dest_bit(opc) && s_reg.ir[DEST_BIT])
		|| (opc == OP_MOVMA) || (opc == OP_SETB) || (opc == OP_CLRB);
	assign sp_dec = s_reg.sp - 3'h1;

	// immediate forms take the literal; move to memory passes the accumulator
	always_comb begin
		if ((opc >= OP_ADDX && opc <= OP_XORX) || opc == OP_MOVAX) begin
			opnd = s_reg.ir[7:0];
		end else if (opc == OP_MOVMA) begin
			opnd = s_reg.acc;
		end else begin
			opnd = dmem_rdata_i;
		end
	end

	assign alu_bus.op      = alu_sel(opc);
	assign alu_bus.a       = s_reg.acc;
	assign alu_bus.b       = opnd;
	assign alu_bus.cin     = s_reg.carry;
	assign alu_bus.bit_sel = bsel;

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		s_next     = s_reg;
		s_next.we  = 1'b0;
		s_next.cyc = fetch_en;

		// execute in the third clock so memory writes land before the next fetch
		if (exec_en && s_reg.seq == SEQ_RUN) begin
			case (opc)
				OP_NOP: begin
				end
				OP_MOVAM, OP_MOVAX: s_next.acc = opnd;
				OP_JMP: begin
					s_next.pc  = s_reg.ir[PC_W-1:0]; // [RULE6]
					s_next.seq = SEQ_FLUSH; // [RULE2]
				end
				OP_CALL: begin
					s_next.stack[s_reg.sp] = s_reg.pc; // [RULE6]
					s_next.sp  = s_reg.sp + 3'h1;
					s_next.pc  = s_reg.ir[PC_W-1:0];
					s_next.seq = SEQ_FLUSH; // [RULE2]
				end
				OP_RET, OP_INTERRUPT_RETURN_INSTRUCTION: begin
					s_next.sp  = sp_dec;
					s_next.pc  = s_reg.stack[sp_dec]; // [RULE6]
					s_next.seq = SEQ_FLUSH; // [RULE2]
					if (opc == OP_INTERRUPT_RETURN_INSTRUCTION) begin
						s_next.gie = 1'b1; // [RULE14]
					end
				end
				OP_SZ: begin
					if (dmem_rdata_i == 8'h00) begin
						s_next.pc  = s_reg.pc + 11'h001; // [RULE5]
						s_next.seq = SEQ_FLUSH; // [RULE4]
					end
				end
				OP_SZB: begin
					if (!dmem_rdata_i[bsel]) begin
						s_next.pc  = s_reg.pc + 11'h001; // [RULE5]
						s_next.seq = SEQ_FLUSH; // [RULE4]
					end
				end
				OP_TBLP: s_next.tblp = {s_reg.ir[DEST_BIT:DEST_BIT-2], s_reg.acc};
				OP_TBLRD: s_next.seq = SEQ_TABLE; // [RULE12]
				default: begin
					// data path instructions, operand from sector 0, the literal or the accumulator
					if (opc == OP_ADD || opc == OP_SUB || opc == OP_ADDX
						|| opc == OP_SUBX || opc == OP_RRC || opc == OP_RLC) begin
						s_next.carry = alu_bus.cout; // [RULE7] [RULE10]
					end
					if (opc >= OP_ADD && opc <= OP_DEC
						|| opc >= OP_ADDX && opc <= OP_XORX) begin
						s_next.zero = alu_bus.zero; // [RULE9]
					end
					if (!to_mem) begin
						s_next.acc = alu_bus.res; // [RULE8] [RULE9]
					end else if (s_reg.dmem_addr == PROGRAM_COUNTER_LOW_BYTE_ADDR) begin
						s_next.pc  = {s_reg.pc[PC_W-1:8], alu_bus.res}; // [RULE3]
						s_next.seq = SEQ_FLUSH; // [RULE3]
					end else begin
						s_next.wdata = alu_bus.res; // [RULE11]
						s_next.we    = 1'b1;
					end
				end
			endcase
			s_next.pmem_addr = (s_next.seq == SEQ_TABLE) ? s_reg.tblp : s_next.pc;
		end

		// fourth clock: take the next word, or spend the extra cycle
		if (fetch_en) begin
			case (s_reg.seq)
				SEQ_RUN: begin
					s_next.ir        = pmem_data_i;
					s_next.dmem_addr = pmem_data_i[7:0]; // [RULE13]
					s_next.pc        = s_reg.pc + 11'h001;
					s_next.pmem_addr = s_reg.pc + 11'h001;
				end
				SEQ_FLUSH: begin
					// the slot after the redirect runs as a bubble
					s_next.ir  = BUBBLE_IR; // [RULE15]
					s_next.seq = SEQ_RUN;
				end
				SEQ_TABLE: begin
					s_next.acc       = pmem_data_i[7:0]; // [RULE12]
					s_next.ir        = BUBBLE_IR; // [RULE15]
					s_next.pmem_addr = s_reg.pc;
					s_next.seq       = SEQ_RUN;
				end
				default: s_next.seq = SEQ_RUN;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg           <= '0;
			s_reg.seq       <= SEQ_RUN;
			s_reg.pc        <= RESET_PC;
			s_reg.pmem_addr <= RESET_PC;
			s_reg.ir        <= BUBBLE_IR;
			s_reg.acc       <= RESET_ACC;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign pmem_addr_o               = s_reg.pmem_addr;
	assign dmem_addr_o               = s_reg.dmem_addr;
	assign dmem_wdata_o              = s_reg.wdata;
	assign dmem_we_o                 = s_reg.we;
	assign acc_o                     = s_reg.acc;
	assign carry_o                   = s_reg.carry;
	assign zero_o                    = s_reg.zero;
	assign global_interrupt_enable_o = s_reg.gie;
	assign instr_cycle_o             = s_reg.cyc;
endmodule // ict_core

// >>> rtl/ict_pkg.sv
package ict_pkg;

	// ----------------------------------------------------------------
	// widths and timing
	// ----------------------------------------------------------------
	localparam int unsigned PC_W            = 11;
	localparam int unsigned INSTR_W         = 16;
	localparam int unsigned DATA_W          = 8;
	localparam int unsigned STACK_DEPTH     = 8;
	localparam int unsigned SP_W            = 3;
	localparam logic [1:0]  CLKS_PER_CYCLE  = 2'h3; // four clocks, counted 0..3
	localparam logic [1:0]  PHASE_EXEC      = 2'h2;
	localparam logic [1:0]  PHASE_FETCH     = 2'h3;

	// ----------------------------------------------------------------
	// data memory map, sector 0 only
	// ----------------------------------------------------------------
	localparam logic [7:0]  PROGRAM_COUNTER_LOW_BYTE_ADDR = 8'h06;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [PC_W-1:0]    RESET_PC   = 11'h000;
	localparam logic [DATA_W-1:0]  RESET_ACC  = 8'h00;
	localparam logic [INSTR_W-1:0] BUBBLE_IR  = 16'h0000;

	// ----------------------------------------------------------------
	// instruction word: [15:11] opcode, [10] to-memory or bit index
	// [10:8], [7:0] data address or immediate, [10:0] jump target
	// ----------------------------------------------------------------
	localparam int unsigned OPC_MSB = 15;
	localparam int unsigned OPC_LSB = 11;
	localparam int unsigned DEST_BIT = 10;

	localparam logic [4:0] OP_NOP   = 5'h00;
	localparam logic [4:0] OP_MOVAM = 5'h01;
	localparam logic [4:0] OP_MOVMA = 5'h02;
	localparam logic [4:0] OP_MOVAX = 5'h03;
	localparam logic [4:0] OP_ADD   = 5'h04;
	localparam logic [4:0] OP_SUB   = 5'h05;
	localparam logic [4:0] OP_AND   = 5'h06;
	localparam logic [4:0] OP_OR    = 5'h07;
	localparam logic [4:0] OP_XOR   = 5'h08;
	localparam logic [4:0] OP_CPL   = 5'h09;
	localparam logic [4:0] OP_INC   = 5'h0A;
	localparam logic [4:0] OP_DEC   = 5'h0B;
	localparam logic [4:0] OP_RR    = 5'h0C;
	localparam logic [4:0] OP_RL    = 5'h0D;
	localparam logic [4:0] OP_RRC   = 5'h0E;
	localparam logic [4:0] OP_RLC   = 5'h0F;
	localparam logic [4:0] OP_ADDX  = 5'h10;
	localparam logic [4:0] OP_SUBX  = 5'h11;
	localparam logic [4:0] OP_ANDX  = 5'h12;
	localparam logic [4:0] OP_ORX   = 5'h13;
	localparam logic [4:0] OP_XORX  = 5'h14;
	localparam logic [4:0] OP_SETB  = 5'h15;
	localparam logic [4:0] OP_CLRB  = 5'h16;
	localparam logic [4:0] OP_SZ    = 5'h17;
	localparam logic [4:0] OP_SZB   = 5'h18;
	localparam logic [4:0] OP_JMP   = 5'h19;
	localparam logic [4:0] OP_CALL  = 5'h1A;
	localparam logic [4:0] OP_RET   = 5'h1B;
	localparam logic [4:0] OP_INTERRUPT_RETURN_INSTRUCTION  = 5'h1C;
	localparam logic [4:0] OP_TBLRD = 5'h1D;
	localparam logic [4:0] OP_TBLP  = 5'h1E;

	typedef enum logic [3:0] {
		ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_CPL, ALU_INC, ALU_DEC,
		ALU_RR, ALU_RL, ALU_RRC, ALU_RLC, ALU_PASS, ALU_SETB, ALU_CLRB
	} ict_alu_op_t;

	typedef enum logic [2:0] {
		SEQ_RUN   = 3'b001,
		SEQ_FLUSH = 3'b010,
		SEQ_TABLE = 3'b100
	} ict_seq_t;

endpackage

// >>> rtl/ict_alu_if.sv
`timescale 1ns/100ps
interface ict_alu_if;
	import ict_pkg::*;
	ict_alu_op_t       op;
	logic [7:0]        a;
	logic [7:0]        b;
	logic              cin;
	logic [2:0]        bit_sel;
	logic [7:0]        res;
	logic              cout;
	logic              zero;

	modport core (output op, a, b, cin, bit_sel, input res, cout, zero);
	modport alu  (input op, a, b, cin, bit_sel, output res, cout, zero);
endinterface

// >>> rtl/ict_phase.sv
`timescale 1ns/100ps
module ict_phase (
	input  wire logic clk_i,
	input  wire logic rst_i,
	output logic      exec_o,
	output logic      fetch_o
);
	import ict_pkg::*;

	typedef struct packed {
		logic [1:0] cnt;
	} ict_phase_state_t;

	ict_phase_state_t s_reg;
	ict_phase_state_t s_next;

	// ----------------------------------------------------------------
	// four clocks per instruction cycle
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.cnt = (s_reg.cnt == CLKS_PER_CYCLE) ? 2'h0 : s_reg.cnt + 2'h1; // [RULE1]
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign exec_o  = (s_reg.cnt == PHASE_EXEC);
	assign fetch_o = (s_reg.cnt == PHASE_FETCH);
endmodule // ict_phase

// >>> rtl/ict_alu.sv
`timescale 1ns/100ps
module ict_alu (
	ict_alu_if.alu port_a
);
	import ict_pkg::*;

	logic [8:0] wide;

	always_comb begin
		wide = 9'h000;
		port_a.cout = 1'b0;
		case (port_a.op)
			ALU_ADD: begin
				wide = {1'b0, port_a.a} + {1'b0, port_a.b};
				port_a.cout = wide[8]; // [RULE7]
			end
			ALU_SUB: begin
				wide = {1'b0, port_a.a} - {1'b0, port_a.b};
				port_a.cout = ~wide[8]; // [RULE7]
			end
			ALU_AND:  wide = {1'b0, port_a.a & port_a.b}; // [RULE9]
			ALU_OR:   wide = {1'b0, port_a.a | port_a.b};
			ALU_XOR:  wide = {1'b0, port_a.a ^ port_a.b};
			ALU_CPL:  wide = {1'b0, ~port_a.b};
			ALU_INC:  wide = {1'b0, port_a.b + 8'h01}; // [RULE8]
			ALU_DEC:  wide = {1'b0, port_a.b - 8'h01}; // [RULE8]
			ALU_RR:   wide = {1'b0, port_a.b[0], port_a.b[7:1]}; // [RULE10]
			ALU_RL:   wide = {1'b0, port_a.b[6:0], port_a.b[7]};
			ALU_RRC: begin
				wide = {1'b0, port_a.cin, port_a.b[7:1]};
				port_a.cout = port_a.b[0]; // [RULE10]
			end
			ALU_RLC: begin
				wide = {1'b0, port_a.b[6:0], port_a.cin};
				port_a.cout = port_a.b[7]; // [RULE10]
			end
			ALU_SETB: wide = {1'b0, port_a.b | (8'h01 << port_a.bit_sel)}; // [RULE11]
			ALU_CLRB: wide = {1'b0, port_a.b & ~(8'h01 << port_a.bit_sel)}; // [RULE11]
			ALU_PASS: wide = {1'b0, port_a.b};
			default:  wide = 9'h000;
		endcase
		port_a.res  = wide[7:0];
		port_a.zero = (wide[7:0] == 8'h00);
	end
endmodule // ict_alu

// >>> bench/ict_core_properties.sv
`timescale 1ns/100ps
module ict_core_properties
	import ict_pkg::*;
(
	input wire logic                        clk_i,
	input wire logic                        rst_i,
	input wire logic [ict_pkg::INSTR_W-1:0] pmem_data_i,
	input wire logic [ict_pkg::DATA_W-1:0]  dmem_rdata_i,
	input wire logic [ict_pkg::PC_W-1:0]    pmem_addr_o,
	input wire logic [ict_pkg::DATA_W-1:0]  dmem_addr_o,
	input wire logic [ict_pkg::DATA_W-1:0]  dmem_wdata_o,
	input wire logic                        dmem_we_o,
	input wire logic [ict_pkg::DATA_W-1:0]  acc_o,
	input wire logic                        carry_o,
	input wire logic                        zero_o,
	input wire logic                        global_interrupt_enable_o,
	input wire logic                        instr_cycle_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ------------------------------------------------
	// sequencer timing
	// ------------------------------------------------
	cycle_period_a: assert property (
		instr_cycle_o |=> !instr_cycle_o [*3] ##1 instr_cycle_o)
		else $error("instruction cycle is not four clocks");
	// table read loads the accumulator on the fetch edge, not the execute edge
	acc_exec_edge_a: assert property (
		$changed(acc_o) |-> $past(instr_cycle_o, 3) || instr_cycle_o)
		else $error("accumulator changed off the execute or table edge");
	flag_exec_edge_a: assert property (
		($changed(carry_o) || $changed(zero_o)) |-> $past(instr_cycle_o, 3))
		else $error("flags changed off the execute edge");
	addr_fetch_edge_a: assert property ($changed(dmem_addr_o) |-> instr_cycle_o)
		else $error("data address moved off the fetch edge");
	pc_move_edge_a: assert property (
		$changed(pmem_addr_o) |-> $past(instr_cycle_o, 3) || instr_cycle_o)
		else $error("program address moved off the execute or fetch edge");
	// ------------------------------------------------
	// data memory writes
	// ------------------------------------------------
	write_phase_a: assert property (dmem_we_o |=> instr_cycle_o)
		else $error("write strobe not in last clock of the cycle");
	single_write_a: assert property (dmem_we_o |=> !dmem_we_o [*3])
		else $error("more than one write in a cycle");
	pcl_no_write_a: assert property (
		dmem_we_o |-> dmem_addr_o != PROGRAM_COUNTER_LOW_BYTE_ADDR)
		else $error("counter low byte write reached memory");
	// ------------------------------------------------
	// interrupt enable
	// ------------------------------------------------
	gie_rise_edge_a: assert property (
		$rose(global_interrupt_enable_o) |-> $past(instr_cycle_o, 3))
		else $error("interrupt enable rose off the execute edge");
	gie_never_falls_a: assert property (!$fell(global_interrupt_enable_o))
		else $error("interrupt enable cleared without reset");
endmodule // ict_core_properties

bind ict_core ict_core_properties u_props (
	.clk_i                     (clk_i),
	.rst_i                     (rst_i),
	.pmem_data_i               (pmem_data_i),
	.dmem_rdata_i              (dmem_rdata_i),
	.pmem_addr_o               (pmem_addr_o),
	.dmem_addr_o               (dmem_addr_o),
	.dmem_wdata_o              (dmem_wdata_o),
	.dmem_we_o                 (dmem_we_o),
	.acc_o                     (acc_o),
	.carry_o                   (carry_o),
	.zero_o                    (zero_o),
	.global_interrupt_enable_o (global_interrupt_enable_o),
	.instr_cycle_o             (instr_cycle_o)
);

// >>> bench/instruction_cycle_timing_tb.sv
`timescale 1ns/100ps
module instruction_cycle_timing_tb;
	import ict_pkg::*;
	// ------------------------------------------------
	// clock, memories, counters
	// ------------------------------------------------
	logic               clk_i        = 1'b0;
	logic               rst_i        = 1'b1;
	logic [INSTR_W-1:0] pmem_data_i  = 16'h0000;
	logic [DATA_W-1:0]  dmem_rdata_i = 8'h00;
	logic [PC_W-1:0]    pmem_addr_o;
	logic [DATA_W-1:0]  dmem_addr_o, dmem_wdata_o, acc_o;
	logic               dmem_we_o, carry_o, zero_o, gie_o, cyc_o;
	logic [15:0]        rom [2048];
	logic [7:0]         ram [256];
	logic               wr  [256];
	int                 wt  [256];
	int                 cyc = 0;
	int                 fail_count = 0;
	int                 total_checks = 0;
	logic [15:0]        prog [$];

	initial begin
		forever #5 clk_i = ~clk_i;
	end

	ict_core dut (
		.clk_i                     (clk_i),
		.rst_i                     (rst_i),
		.pmem_data_i               (pmem_data_i),
		.dmem_rdata_i              (dmem_rdata_i),
		.pmem_addr_o               (pmem_addr_o),
		.dmem_addr_o               (dmem_addr_o),
		.dmem_wdata_o              (dmem_wdata_o),
		.dmem_we_o                 (dmem_we_o),
		.acc_o                     (acc_o),
		.carry_o                   (carry_o),
		.zero_o                    (zero_o),
		.global_interrupt_enable_o (gie_o),
		.instr_cycle_o             (cyc_o)
	);

	// memories answer off the falling edge; writes land on the strobe's closing edge
	always @(negedge clk_i) begin
		pmem_data_i  <= rom[pmem_addr_o];
		dmem_rdata_i <= ram[dmem_addr_o];
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (dmem_we_o === 1'b1) begin
			ram[dmem_addr_o] <= dmem_wdata_o;
			wt[dmem_addr_o]  <= cyc;
			wr[dmem_addr_o]  <= 1'b1;
		end
		// all scenarios need well under a thousand clocks
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	// ------------------------------------------------
	// shared tasks
	// ------------------------------------------------
	function automatic logic [15:0] w(input logic [4:0] op, input logic [10:0] f);
		return {op, f};
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// core held in reset while memories are rewritten, so no stray writes land
	task automatic load();
		@(negedge clk_i);
		rst_i = 1'b1;
		// one more edge lets a strobe still pending from the last run land first
		@(negedge clk_i);
		for (int i = 0; i < 2048; i++) rom[i] = 16'h0000;
		for (int i = 0; i < 256; i++) begin
			ram[i] = 8'h00;
			wr[i] = 1'b0;
			wt[i] = 0;
		end
		foreach (prog[i]) rom[i] = prog[i];
	endtask

	task automatic run(input int n);
		repeat (8) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (4 * n + 8) @(negedge clk_i);
	endtask

	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	task automatic scen_timing();
		int e [6] = '{12, 12, 8, 12, 12, 16};
		int n = 0;
		prog = '{w(OP_MOVMA, 11'h020), w(OP_JMP, 11'h003), w(OP_MOVMA, 11'h02F),
			w(OP_MOVMA, 11'h021), w(OP_SZ, 11'h030), w(OP_MOVMA, 11'h02F),
			w(OP_MOVMA, 11'h022), w(OP_SZ, 11'h031), w(OP_MOVMA, 11'h023),
			w(OP_CALL, 11'h020), w(OP_MOVMA, 11'h025), w(OP_MOVAX, 11'h010),
			w(OP_MOVMA, 11'h006), w(OP_MOVMA, 11'h02F), 16'h0000, 16'h0000,
			w(OP_MOVMA, 11'h026), w(OP_JMP, 11'h011)};
		load();
		rom[32] = w(OP_MOVMA, 11'h024);
		rom[33] = w(OP_RET, 11'h000);
		ram[8'h31] = 8'h01;
		run(30);
		for (int i = 0; i < 6; i++) begin
			chk(8'(wt[8'h21 + i] - wt[8'h20 + i]), 8'(e[i]));
		end
		chk({7'h00, wr[8'h2F]}, 8'h00);
		chk({7'h00, wr[8'h06]}, 8'h00);
		chk(ram[8'h26], 8'h10);
		chk({7'h00, gie_o}, 8'h00);
		repeat (40) begin
			@(negedge clk_i);
			if (cyc_o === 1'b1) n++;
		end
		chk(8'(n), 8'h0A);
	endtask

	task automatic scen_logic();
		prog = '{w(OP_MOVAM, 11'h040), w(OP_RR, 11'h440), w(OP_RL, 11'h041),
			w(OP_MOVMA, 11'h051), w(OP_AND, 11'h442), w(OP_OR, 11'h043),
			w(OP_XOR, 11'h443), w(OP_INC, 11'h041), w(OP_MOVMA, 11'h052),
			w(OP_DEC, 11'h444), w(OP_ADD, 11'h045), w(OP_MOVMA, 11'h053),
			w(OP_MOVAX, 11'h020), w(OP_SUBX, 11'h007)};
		load();
		ram[8'h40] = 8'h81;
		ram[8'h41] = 8'h96;
		ram[8'h42] = 8'h0F;
		ram[8'h43] = 8'h40;
		ram[8'h44] = 8'h01;
		ram[8'h45] = 8'h69;
		ram[8'h53] = 8'hEE;
		run(20);
		chk(ram[8'h40], 8'hC0);
		chk(ram[8'h51], 8'h2D);
		chk(ram[8'h42], 8'h0D);
		chk(ram[8'h43], 8'h2D);
		chk(ram[8'h52], 8'h97);
		chk(ram[8'h44], 8'h00);
		chk(ram[8'h53], 8'h00);
		chk(acc_o, 8'h19);
		chk({7'h00, carry_o}, 8'h01);
		chk({7'h00, zero_o}, 8'h00);
	endtask

	task automatic scen_arith();
		prog = '{w(OP_MOVAX, 11'h0F0), w(OP_ADDX, 11'h020), w(OP_MOVMA, 11'h050),
			w(OP_RLC, 11'h041), w(OP_MOVMA, 11'h051), w(OP_RRC, 11'h440),
			w(OP_RLC, 11'h041), w(OP_SUB, 11'h042), w(OP_MOVMA, 11'h052),
			w(OP_INC, 11'h442), w(OP_DEC, 11'h041), w(OP_MOVMA, 11'h053),
			w(OP_CPL, 11'h041), w(OP_ANDX, 11'h00F), w(OP_ORX, 11'h050),
			w(OP_XORX, 11'h05A)};
		load();
		ram[8'h40] = 8'h81;
		ram[8'h41] = 8'h05;
		ram[8'h42] = 8'hFF;
		run(24);
		chk(ram[8'h50], 8'h10);
		chk(ram[8'h51], 8'h0B);
		chk(ram[8'h40], 8'h40);
		chk(ram[8'h52], 8'h0C);
		chk({7'h00, carry_o}, 8'h00);
		chk(ram[8'h42], 8'h00);
		chk(ram[8'h53], 8'h04);
		chk(acc_o, 8'h00);
		chk({7'h00, zero_o}, 8'h01);
	endtask

	task automatic scen_bits();
		prog = '{w(OP_SETB, 11'h160), w(OP_CLRB, 11'h760), w(OP_SZB, 11'h360),
			w(OP_MOVAX, 11'h011), w(OP_MOVMA, 11'h061), w(OP_SZB, 11'h060),
			w(OP_MOVAX, 11'h033)};
		load();
		ram[8'h60] = 8'hA5;
		run(14);
		chk(ram[8'h60], 8'h27);
		chk(ram[8'h61], 8'h00);
		chk(acc_o, 8'h33);
	endtask

	task automatic scen_table();
		prog = '{w(OP_MOVAX, 11'h080), w(OP_TBLP, 11'h100), w(OP_TBLRD, 11'h000),
			w(OP_CALL, 11'h008), w(OP_MOVMA, 11'h070), w(OP_JMP, 11'h005)};
		load();
		rom[8] = w(OP_INTERRUPT_RETURN_INSTRUCTION, 11'h000);
		rom[384] = 16'h12C3;
		run(16);
		chk(ram[8'h70], 8'hC3);
		chk({7'h00, gie_o}, 8'h01);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		scen_timing();
		scen_arith();
		scen_logic();
		scen_bits();
		scen_table();
		tally_and_finish();
	end
endmodule // instruction_cycle_timing_tb
